// ===== core/unit_cfg.svh
/*
  Constants of the compare and PWM unit: register byte offsets, field
  positions, reset values, mode codes and prescale counts.
  Assumes inclusion by bare name from every design file that needs them.
*/
`ifndef UNIT_CFG_SVH
`define UNIT_CFG_SVH

// Register byte offsets, one 32-bit word each
`define OFS_CTRL 8'h00
`define OFS_CMPL 8'h04
`define OFS_CMPH 8'h08
`define OFS_PERIOD 8'h0C
`define OFS_PTCON 8'h10
`define OFS_TBCON 8'h14
`define OFS_TBCNT 8'h18
`define OFS_STAT 8'h1C
`define OFS_MASK 8'h20
`define OFS_PTCNT 8'h24

// Control register fields
`define CTRL_MODE_LO 0
`define CTRL_MODE_HI 3
`define CTRL_DUTY_LO 4
`define CTRL_DUTY_HI 5
`define CTRL_TRIG 6

// Mode codes
`define MODE_OFF 4'h0
`define MODE_CMP_TGL 4'h2
`define MODE_CMP_SET 4'h8
`define MODE_CMP_CLR 4'h9
`define MODE_CMP_TRIG 4'hB
`define MODE_PWM 4'hC

// Period timer control fields
`define PT_ON 0
`define PT_PRE_LO 1
`define PT_PRE_HI 2

// Time base control fields
`define TB_ON 0
`define TB_EXT 1

// Status and mask field
`define EVT_FLAG 0

// Prescaler terminal counts for divide by 1, 4, 16 and 64
`define PRE_DIV1 6'h00
`define PRE_DIV4 6'h03
`define PRE_DIV16 6'h0F
`define PRE_DIV64 6'h3F

// Reset values
`define RST_CTRL 7'h00
`define RST_BYTE 8'h00
`define RST_PTCON 3'h0
`define RST_TBCON 2'h0
`define RST_TBCNT 16'h0000
`define RST_DUTY 10'h000

`endif

// ===== core/unit_pkg.sv
/*
  Types shared by the compare and PWM unit.
  Assumes the constants header is compiled alongside.
*/
package unit_pkg;

  typedef logic [7:0] addr_t;
  typedef logic [31:0] data_t;
  typedef logic [3:0] mode_t;
  typedef logic [9:0] duty_t;

endpackage : unit_pkg

// ===== core/sync2.sv
/*
  Two-flop synchroniser for a single level from outside the clock domain.
  Assumes the input is a slow level compared with the clock.
*/
`timescale 1ns/1ns
module sync2 (
  input wire logic clock, // System clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic din, // Level from outside the domain
  output logic dout // Synchronised level
);

  logic meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_ff <= din;
      dout <= meta_ff;
    end
  end

endmodule : sync2

// ===== core/compare_and_pwm_unit.sv
/*
  Compare and PWM unit with an APB register slave, a 16-bit compare time
  base, an 8-bit period timer extended to ten bits, and one level interrupt.
  Assumes a 50 MHz clock, an APB master, and an external time-base clock
  that is slow next to the system clock.
*/
// Notes on behaviour
// [RULE_01] Writing zero to the control register forces the output latch low.
// [RULE_02] Software runs the time base internally or on the synchronised external clock.
// [RULE_03] The time base uses the system tick or an external clock, nothing faster.
// [RULE_04] Every mode sets the event flag on its own event.
// [RULE_05] A compare match issues a conversion trigger when the trigger is selected.
// [RULE_06] If the match vanishes before the reset tick, the time base is not reset.
// [RULE_07] In sleep only an externally clocked time base runs; events may wake. The period timer still counts in sleep.
// [RULE_08] The unit output also goes to other on-chip peripherals.
// [RULE_09] Software makes the pin an output and routes the unit to it.
// [RULE_10] PWM mode makes a waveform of up to ten bits resolution.
// [RULE_11] Period, period control, low compare value and control set PWM.
// [RULE_12] High is the pulse; 0% stays low and 100% stays high.
// [RULE_13] One period is one high plus one low part, repeating continuously.
// [RULE_14] A match on the time-base tick sets the flag and applies the action.
// [RULE_15] PWM rises at period rollover and falls when the timer reaches duty.
`timescale 1ns/1ns
`include "unit_cfg.svh"
module compare_and_pwm_unit (
  input wire logic clock, // 50 MHz system clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write direction
  input wire unit_pkg::addr_t paddr, // APB byte address
  input wire unit_pkg::data_t pwdata, // APB write data
  output logic pready, // APB ready
  output unit_pkg::data_t prdata, // APB read data
  output logic pslverr, // APB error on unmapped address
  input wire logic ext_clk, // External time-base clock pin
  input wire logic sleep, // Core sleep, system tick stopped
  output logic pin_out, // Unit output towards the pin
  output logic periph_out, // Unit output towards other peripherals
  output logic adc_trig, // One-cycle conversion trigger
  output logic irq, // Level interrupt
  output logic wake // Wake request during sleep
);
  import unit_pkg::*;

  logic [6:0] ctrl_ff;
  logic [7:0] cmpl_ff;
  logic [7:0] cmph_ff;
  logic [7:0] period_ff;
  logic [2:0] ptcon_ff;
  logic [1:0] tbcon_ff;
  logic [15:0] tb_cnt_ff;
  logic [15:0] nxt_tb_cnt;
  logic stat_ff;
  logic mask_ff;
  logic [7:0] tmr_ff;
  logic [1:0] sub_ff;
  logic [5:0] pre_ff;
  duty_t duty_lat_ff;
  logic out_ff;
  logic nxt_out;
  logic pend_rst_ff;
  logic trig_ff;
  logic ext_d_ff;
  data_t prdata_ff;
  logic ext_s;

  // APB decode
  wire setup_w = psel & ~penable;
  wire wr_w = psel & penable & pwrite;
  wire sel_ctrl = (paddr == `OFS_CTRL);
  wire sel_cmpl = (paddr == `OFS_CMPL);
  wire sel_cmph = (paddr == `OFS_CMPH);
  wire sel_period = (paddr == `OFS_PERIOD);
  wire sel_ptcon = (paddr == `OFS_PTCON);
  wire sel_tbcon = (paddr == `OFS_TBCON);
  wire sel_tbcnt = (paddr == `OFS_TBCNT);
  wire sel_stat = (paddr == `OFS_STAT);
  wire sel_mask = (paddr == `OFS_MASK);
  wire sel_ptcnt = (paddr == `OFS_PTCNT);
  wire mapped_w = sel_ctrl | sel_cmpl | sel_cmph | sel_period | sel_ptcon |
                  sel_tbcon | sel_tbcnt | sel_stat | sel_mask | sel_ptcnt;
  wire wr_ctrl = wr_w & sel_ctrl;
  wire wr_tbcnt = wr_w & sel_tbcnt;
  wire ctrl_zero_w = wr_ctrl & (pwdata[6:0] == `RST_CTRL);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped_w;

  // Mode decode
  wire mode_t mode_w = ctrl_ff[`CTRL_MODE_HI:`CTRL_MODE_LO];
  wire is_pwm = (mode_w == `MODE_PWM);
  wire is_trig = (mode_w == `MODE_CMP_TRIG);
  wire is_cmp = (mode_w == `MODE_CMP_SET) | (mode_w == `MODE_CMP_CLR) |
                (mode_w == `MODE_CMP_TGL) | is_trig;

  // External clock edge after two-flop synchroniser
  sync2 u_ext_sync (
    .clock(clock),
    .arst_n(arst_n),
    .din(ext_clk),
    .dout(ext_s)
  );
  wire ext_rise = ext_s & ~ext_d_ff;

  // Time-base tick: internal tick stops in sleep, external keeps going
  wire tb_tick = tbcon_ff[`TB_ON] & (tbcon_ff[`TB_EXT] ? ext_rise : ~sleep); // RULE_02 RULE_03 RULE_07
  wire [15:0] cmp_val = {cmph_ff, cmpl_ff};
  wire cmp_eq = (tb_cnt_ff == cmp_val);
  wire match_w = is_cmp & tb_tick & cmp_eq; // RULE_14
  // The count has moved on by one at the match tick, so the reset tick still
  // sees the match when the count sits one above the compare pair; a rewritten
  // pair breaks this and the reset is skipped
  wire [15:0] cmp_next = cmp_val + 16'h0001;
  wire tb_rst_w = tb_tick & pend_rst_ff & (tb_cnt_ff == cmp_next); // RULE_06

  // Time-base next value: software write, reset after trigger, or count
  always_comb begin
    nxt_tb_cnt = tb_cnt_ff;
    if (wr_tbcnt) begin
      nxt_tb_cnt = pwdata[15:0];
    end else if (tb_rst_w) begin
      nxt_tb_cnt = `RST_TBCNT; // RULE_06
    end else if (tb_tick) begin
      nxt_tb_cnt = tb_cnt_ff + 16'h0001;
    end
  end

  // Period timer with prescaler, extended to ten bits by the sub count
  wire [1:0] pre_sel = ptcon_ff[`PT_PRE_HI:`PT_PRE_LO];
  wire [5:0] pre_lim = (pre_sel == 2'h0) ? `PRE_DIV1 :
                       (pre_sel == 2'h1) ? `PRE_DIV4 :
                       (pre_sel == 2'h2) ? `PRE_DIV16 : `PRE_DIV64;
  wire pt_on = ptcon_ff[`PT_ON]; // RULE_11
  wire pt_tick = pt_on & (pre_ff == pre_lim);
  wire [9:0] pos_w = {tmr_ff, sub_ff}; // RULE_10
  wire roll_w = pt_tick & (tmr_ff == period_ff) & (sub_ff == 2'h3); // RULE_13
  wire [9:0] nxt_pos = roll_w ? 10'h000 : pos_w + 10'h001;
  wire duty_t duty_new = {cmpl_ff, ctrl_ff[`CTRL_DUTY_HI:`CTRL_DUTY_LO]}; // RULE_11
  wire pwm_roll = is_pwm & roll_w;

  // Unit events: compare match or PWM period end
  wire evt_w = match_w | pwm_roll; // RULE_04

  // Output latch next value
  always_comb begin
    nxt_out = out_ff;
    if (ctrl_zero_w) begin
      nxt_out = 1'b0; // RULE_01
    end else if (is_pwm) begin
      if (pwm_roll) begin
        nxt_out = (duty_new != `RST_DUTY); // RULE_12 RULE_15
      end else if (pt_tick && (nxt_pos == duty_lat_ff)) begin
        nxt_out = 1'b0; // RULE_15
      end
    end else if (match_w) begin
      if (mode_w == `MODE_CMP_SET) begin
        nxt_out = 1'b1; // RULE_14
      end else if (mode_w == `MODE_CMP_CLR) begin
        nxt_out = 1'b0;
      end else if (mode_w == `MODE_CMP_TGL) begin
        nxt_out = ~out_ff;
      end
    end
  end

  // Read data selection
  wire data_t rd_w = ({32{sel_ctrl}} & {25'h0000000, ctrl_ff}) |
                     ({32{sel_cmpl}} & {24'h000000, cmpl_ff}) |
                     ({32{sel_cmph}} & {24'h000000, cmph_ff}) |
                     ({32{sel_period}} & {24'h000000, period_ff}) |
                     ({32{sel_ptcon}} & {29'h00000000, ptcon_ff}) |
                     ({32{sel_tbcon}} & {30'h00000000, tbcon_ff}) |
                     ({32{sel_tbcnt}} & {16'h0000, tb_cnt_ff}) |
                     ({32{sel_stat}} & {31'h00000000, stat_ff}) |
                     ({32{sel_mask}} & {31'h00000000, mask_ff}) |
                     ({32{sel_ptcnt}} & {22'h000000, pos_w});

  // Read data captured in the setup cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prdata_ff <= 32'h00000000;
    end else if (setup_w) begin
      prdata_ff <= rd_w;
    end
  end
  assign prdata = prdata_ff;

  // Control and compare registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= `RST_CTRL;
      cmpl_ff <= `RST_BYTE;
      cmph_ff <= `RST_BYTE;
    end else begin
      if (wr_ctrl) ctrl_ff <= pwdata[6:0];
      if (wr_w && sel_cmpl) cmpl_ff <= pwdata[7:0];
      if (wr_w && sel_cmph) cmph_ff <= pwdata[7:0];
    end
  end

  // Timer configuration and interrupt mask registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      period_ff <= `RST_BYTE;
      ptcon_ff <= `RST_PTCON;
      tbcon_ff <= `RST_TBCON;
      mask_ff <= 1'b0;
    end else begin
      if (wr_w && sel_period) period_ff <= pwdata[7:0];
      if (wr_w && sel_ptcon) ptcon_ff <= pwdata[2:0];
      if (wr_w && sel_tbcon) tbcon_ff <= pwdata[1:0];
      if (wr_w && sel_mask) mask_ff <= pwdata[`EVT_FLAG];
    end
  end

  // Sticky event flag, write one to clear, set wins
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stat_ff <= 1'b0;
    end else begin
      stat_ff <= (stat_ff & ~(wr_w & sel_stat & pwdata[`EVT_FLAG])) | evt_w; // RULE_04
    end
  end
  assign irq = stat_ff & mask_ff;
  assign wake = irq & sleep; // RULE_07

  // Compare time base, pending reset and trigger
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tb_cnt_ff <= `RST_TBCNT;
      pend_rst_ff <= 1'b0;
      trig_ff <= 1'b0;
      ext_d_ff <= 1'b0;
    end else begin
      tb_cnt_ff <= nxt_tb_cnt;
      pend_rst_ff <= (match_w & is_trig) | (pend_rst_ff & ~tb_tick); // RULE_06
      trig_ff <= match_w & ctrl_ff[`CTRL_TRIG]; // RULE_05
      ext_d_ff <= ext_s;
    end
  end
  assign adc_trig = trig_ff;

  // Period timer, prescaler and duty latch
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pre_ff <= 6'h00;
      tmr_ff <= `RST_BYTE;
      sub_ff <= 2'h0;
      duty_lat_ff <= `RST_DUTY;
    end else begin
      pre_ff <= (!pt_on || pt_tick) ? 6'h00 : pre_ff + 6'h01;
      if (pt_tick) {tmr_ff, sub_ff} <= nxt_pos; // RULE_13
      if (roll_w) duty_lat_ff <= duty_new; // RULE_10
    end
  end

  // Output latch feeds pin and peripherals alike
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      out_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
    end
  end
  assign pin_out = out_ff;
  assign periph_out = out_ff; // RULE_08

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence s_match;
    match_w;
  endsequence

  sequence s_roll;
    pwm_roll;
  endsequence

  sequence s_pend_tick;
    pend_rst_ff && tb_tick && !wr_tbcnt;
  endsequence

  AST_CTRL_CLEAR: assert property (ctrl_zero_w |=> !pin_out && !periph_out) // RULE_01
    else $error("output not low after control cleared");

  AST_FLAG_SET: assert property (s_match or s_roll |=> stat_ff) // RULE_04
    else $error("event did not set the flag");

  AST_TRIG: assert property (s_match ##0 ctrl_ff[`CTRL_TRIG] |=> adc_trig ##1 !adc_trig) // RULE_05
    else $error("trigger missing or longer than one cycle");

  AST_NO_TRIG: assert property (adc_trig |-> $past(match_w)) // RULE_05
    else $error("trigger without a match");

  AST_SKIP_RESET: assert property (s_pend_tick ##0 (tb_cnt_ff != cmp_next) // RULE_06
    |=> tb_cnt_ff == $past(tb_cnt_ff) + 16'h0001)
    else $error("time base reset although match was removed");

  AST_DO_RESET: assert property (s_pend_tick ##0 (tb_cnt_ff == cmp_next) // RULE_06
    |=> tb_cnt_ff == 16'h0000)
    else $error("time base not reset after trigger");

  AST_SLEEP_HOLD: assert property (sleep && !tbcon_ff[`TB_EXT] && !wr_tbcnt |=> $stable(tb_cnt_ff)) // RULE_07
    else $error("internal time base counted in sleep");

  AST_WAKE: assert property (sleep && stat_ff && mask_ff |-> wake) // RULE_07
    else $error("no wake on enabled event in sleep");

  AST_MATCH_SET: assert property (s_match ##0 (mode_w == `MODE_CMP_SET) && !ctrl_zero_w |=> pin_out) // RULE_14
    else $error("set-on-match did not drive output high");

  AST_PWM_RISE: assert property (s_roll ##0 (duty_new != 10'h000) && !ctrl_zero_w |=> pin_out) // RULE_15
    else $error("PWM did not rise at rollover");

  AST_PWM_ZERO: assert property (s_roll ##0 (duty_new == 10'h000) |=> !pin_out) // RULE_12
    else $error("zero duty did not hold output low");

  AST_PWM_FALL: assert property (is_pwm && pt_tick && !roll_w && nxt_pos == duty_lat_ff // RULE_15
    |=> !pin_out)
    else $error("PWM did not fall at duty value");

  AST_PERIOD: assert property (roll_w |=> tmr_ff == 8'h00 && sub_ff == 2'h0) // RULE_13
    else $error("period timer did not restart at rollover");

  // Compare output actions, trigger selection and the sticky flag
  AST_MATCH_CLR: assert property (s_match ##0 (mode_w == `MODE_CMP_CLR) |=> !pin_out) // RULE_14
    else $error("clear-on-match did not drive output low");

  AST_TOGGLE: assert property (s_match ##0 (mode_w == `MODE_CMP_TGL) && !ctrl_zero_w // RULE_14
    |=> pin_out != $past(pin_out))
    else $error("toggle-on-match did not invert output");

  AST_OUT_HOLD: assert property (!is_pwm && !match_w && !ctrl_zero_w |=> $stable(pin_out)) // RULE_14
    else $error("compare output changed without a match");

  AST_TRIG_OFF: assert property (s_match ##0 !ctrl_ff[`CTRL_TRIG] |=> !adc_trig) // RULE_05
    else $error("trigger issued although not selected");

  AST_STAT_CLEAR: assert property (wr_w && sel_stat && pwdata[`EVT_FLAG] && !evt_w |=> !stat_ff) // RULE_04
    else $error("event flag not cleared by writing one");

  AST_STAT_HOLD: assert property (stat_ff && !(wr_w && sel_stat && pwdata[`EVT_FLAG]) |=> stat_ff) // RULE_04
    else $error("event flag lost without a clear");

endmodule : compare_and_pwm_unit

// ===== verification/pin_load.sv
/*
  Load on the unit's pin: times high part and period of the waveform.
  Assumes the pin is already driven as an output by the unit.
*/
`timescale 1ns/1ns
module pin_load (
  input wire logic clock, // System clock
  input wire logic arst_n, // Reset, active low
  input wire logic pin, // Level at the pin
  input wire logic periph, // Level seen by peripherals
  output logic [15:0] hi_len_ff, // Last high time
  output logic [15:0] per_len_ff, // Last rise to rise time
  output logic [15:0] split_ff // Cycles the copies differ
);
  logic pin_d_ff;
  logic [15:0] hi_ff;
  logic [15:0] per_ff;
  logic rise;
  // Rising edge of the pin as the load sees it
  assign rise = pin && !pin_d_ff;
  // Time the waveform
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      {pin_d_ff, hi_ff, per_ff, hi_len_ff, per_len_ff, split_ff} <= '0;
    end else begin
      pin_d_ff <= pin;
      per_ff <= rise ? 16'h0001 : per_ff + 16'h0001;
      hi_ff <= rise ? 16'h0001 : hi_ff + {15'h0000, pin};
      if (rise) per_len_ff <= per_ff;
      if (!pin && pin_d_ff) hi_len_ff <= hi_ff;
      if (pin !== periph) split_ff <= split_ff + 16'h0001;
    end
  end
endmodule : pin_load

// ===== verification/compare_and_pwm_unit_tb.sv
/*
  Testbench of the compare and PWM unit: registers, compare, PWM, events.
  Assumes the design, its package and constants header are compiled first.
*/
`timescale 1ns/1ns
`include "unit_cfg.svh"
module compare_and_pwm_unit_tb;
  import unit_pkg::*;
  typedef struct {addr_t a; data_t w; data_t r; logic e;} row_t;
  logic clock, arst_n, psel, penable, pwrite, ext_clk, sleep, er;
  addr_t paddr;
  data_t pwdata, prdata, rd, t0;
  logic pready, pslverr, pin_out, periph_out, adc_trig, irq, wake;
  logic [15:0] hi_len, per_len, split;
  int n_fail, check_count, cyc, trig_n;
  // Address, write value, read back, error expected
  row_t rows [10] = '{
    '{`OFS_CTRL, 32'hFFFFFFFF, 32'h0000007F, 1'b0},
    '{`OFS_CMPL, 32'hFFFFFFA5, 32'h000000A5, 1'b0},
    '{`OFS_CMPH, 32'h0000015A, 32'h0000005A, 1'b0},
    '{`OFS_PERIOD, 32'hFFFFFFC3, 32'h000000C3, 1'b0},
    '{`OFS_PTCON, 32'hFFFFFFFE, 32'h00000006, 1'b0},
    '{`OFS_TBCON, 32'hFFFFFFFE, 32'h00000002, 1'b0},
    '{`OFS_MASK, 32'hFFFFFFFF, 32'h00000001, 1'b0},
    '{`OFS_STAT, 32'hFFFFFFFF, 32'h00000000, 1'b0},
    '{`OFS_PTCNT, 32'hFFFFFFFF, 32'h00000000, 1'b0},
    '{8'h28, 32'hFFFFFFFF, 32'h00000000, 1'b1}};

  compare_and_pwm_unit i_dut (.clock(clock), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .ext_clk(ext_clk),
    .sleep(sleep), .pin_out(pin_out), .periph_out(periph_out),
    .adc_trig(adc_trig), .irq(irq), .wake(wake));
  pin_load i_load (.clock(clock), .arst_n(arst_n), .pin(pin_out), .periph(periph_out),
    .hi_len_ff(hi_len), .per_len_ff(per_len), .split_ff(split));

  // Clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Trigger pulses and hang guard
  always @(posedge clock) begin
    if (adc_trig === 1'b1) trig_n++;
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      conclude();
    end
  end

  task conclude;
    $display("checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  task chk(input data_t g, input data_t x);
    check_count++;
    if (g !== x) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
      n_fail++;
    end
  endtask : chk

  // One APB transfer; result left in rd and er
  task apb(input logic w, input addr_t a, input data_t d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input addr_t a, input data_t d);
    apb(1'b1, a, d);
  endtask : wr

  task rdc(input addr_t a, input data_t x);
    apb(1'b0, a, 32'h0);
    chk(rd, x);
  endtask : rdc

  task wait_irq;
    while (irq !== 1'b1) @(negedge clock);
  endtask : wait_irq

  task lvl(input logic x);
    repeat (8) begin
      @(negedge clock);
      chk(pin_out, x);
    end
  endtask : lvl

  // Pulses on the external time-base clock, slow against the system clock
  task ext_pulse(input int n);
    repeat (n) begin
      repeat (4) @(posedge clock);
      ext_clk <= 1'b1;
      repeat (4) @(posedge clock);
      ext_clk <= 1'b0;
    end
  endtask : ext_pulse

  // Restart the time base from zero in the given mode, on the system tick
  task tb_go(input data_t ctl);
    wr(`OFS_TBCON, 32'h0);
    wr(`OFS_TBCNT, 32'h0);
    wr(`OFS_STAT, 32'h1);
    wr(`OFS_CTRL, ctl);
    wr(`OFS_TBCON, 32'h1);
    wait_irq();
  endtask : tb_go

  task pwm(input data_t per, pt, ctl, cl, xp, xh);
    wr(`OFS_PTCON, 32'h0);
    wr(`OFS_PERIOD, per);
    wr(`OFS_CMPL, cl);
    wr(`OFS_CTRL, ctl);
    wr(`OFS_PTCON, pt);
    repeat (3 * xp + 8) @(posedge clock);
    chk(per_len, xp);
    chk(hi_len, xh);
  endtask : pwm

  initial begin
    {arst_n, psel, penable, pwrite, ext_clk, sleep} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    @(negedge clock);
    chk({pready, pin_out, adc_trig, irq, wake}, 32'h10);
    for (int i = 0; i < 10; i++) begin
      rdc(rows[i].a, 32'h0);
      wr(rows[i].a, rows[i].w);
      rdc(rows[i].a, rows[i].r);
      chk(er, rows[i].e);
      wr(rows[i].a, 32'h0);
    end
    $display("test registers done");
    // Compare actions: set, clear, toggle, each with trigger selected
    wr(`OFS_CMPL, 32'h20);
    wr(`OFS_MASK, 32'h1);
    tb_go(32'h48);
    chk(pin_out, 1'b1);
    tb_go(32'h49);
    chk(pin_out, 1'b0);
    tb_go(32'h42);
    chk(periph_out, 1'b1);
    wr(`OFS_CTRL, 32'h0);
    @(negedge clock);
    chk(pin_out, 1'b0);
    // Special mode: the time base restarts at the tick after the match
    tb_go(32'h0B);
    apb(1'b0, `OFS_TBCNT, 32'h0);
    chk(rd[15:0] < 16'h0020, 1'b1);
    chk(trig_n, 3);
    // Match removed between trigger tick and reset tick: the count runs on
    wr(`OFS_TBCON, 32'h0);
    wr(`OFS_TBCNT, 32'h1F);
    wr(`OFS_TBCON, 32'h3);
    ext_pulse(2);
    wr(`OFS_CMPL, 32'h40);
    ext_pulse(1);
    rdc(`OFS_TBCNT, 32'h22);
    $display("test compare done");
    // Interrupt mask, wake in sleep, clear by writing one
    wr(`OFS_MASK, 32'h0);
    @(negedge clock);
    chk(irq, 1'b0);
    wr(`OFS_MASK, 32'h1);
    sleep <= 1'b1;
    @(negedge clock);
    chk(wake, 1'b1);
    wr(`OFS_STAT, 32'h1);
    @(negedge clock);
    chk({irq, wake}, 32'h0);
    apb(1'b0, `OFS_TBCNT, 32'h0);
    t0 = rd;
    rdc(`OFS_TBCNT, t0);
    // External clock keeps the time base going in sleep
    wr(`OFS_TBCON, 32'h0);
    wr(`OFS_TBCNT, 32'h0);
    wr(`OFS_TBCON, 32'h3);
    ext_pulse(5);
    repeat (4) @(posedge clock);
    rdc(`OFS_TBCNT, 32'h5);
    sleep <= 1'b0;
    wr(`OFS_TBCON, 32'h0);
    $display("test sleep done");
    // Waveforms, then 0% and 100%
    pwm(32'h0, 32'h1, 32'h2C, 32'h0, 32'h4, 32'h2);
    pwm(32'h1, 32'h3, 32'h1C, 32'h1, 32'h20, 32'h14);
    rdc(`OFS_STAT, 32'h1);
    // Zero duty from the next rollover, set just after a rise: only the fall of the current pulse follows, no new rise
    while (pin_out !== 1'b0) @(posedge clock);
    while (pin_out !== 1'b1) @(posedge clock);
    wr(`OFS_CMPL, 32'h0);
    wr(`OFS_CTRL, 32'h0C);
    repeat (40) @(posedge clock);
    pwm(32'h0, 32'h1, 32'h0C, 32'h0, 32'h20, 32'h14);
    lvl(1'b0);
    wr(`OFS_CMPL, 32'h1);
    // A timer left above the new period wraps through the rest of the 1024 steps first
    repeat (1040) @(posedge clock);
    lvl(1'b1);
    chk(split, 32'h0);
    $display("test pwm done");
    conclude();
  end
endmodule : compare_and_pwm_unit_tb
